// ### core/nstg_top.sv
// nand strobe timing generator: shapes read and write cycles toward a
// nand flash from counts in a timing register reached over wishbone
// assumes pins and r/b are synchronous to ref_clk_i (40 mhz)
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "nstg_map.svh"

module nstg_top
  import nstg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // nand flash bus
  input wire logic [7:0] dq_i,
  input wire logic rb_i,
  output nstg_pins_t pins_o
);

  // ****************************************************
  // registers
  // ****************************************************
  logic [31:0] timing_ff;
  logic [31:0] tim_act_ff;
  logic [`NSTG_CMD_W-1:0] cmd_ff;
  logic [7:0] rdata_ff;
  logic pend_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  nstg_state_t state_ff;
  nstg_state_t nxt_state;
  nstg_pins_t pins_ff;
  logic ld;
  logic [`NSTG_CNT_W-1:0] ldv;
  logic last;
  logic wb_req;
  logic busy;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign busy = pend_ff | (state_ff != S_IDLE);

  // field widened to a phase length
  function automatic logic [`NSTG_CNT_W-1:0] one(input logic [3:0] f);
    one = {1'b0, f};
  endfunction

  // field doubled, for the ready guard
  function automatic logic [`NSTG_CNT_W-1:0] two(input logic [3:0] f);
    two = {f, 1'b0};
  endfunction

  // one write takes effect per request; ack drops the cycle after
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  // timing register, byte lanes honoured
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      timing_ff <= `NSTG_TIMING_RST;
    end else if (wb_req && wb_we_i && wb_adr_i == `NSTG_OFS_TIMING) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          timing_ff[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
    end
  end

  // command write launches an access; refused while one is running,
  // since there is no queue and a half-run access must not be altered
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cmd_ff <= `NSTG_CMD_RST;
    end else if (wb_req && wb_we_i && wb_adr_i == `NSTG_OFS_CMD &&
                 !busy && wb_sel_i[0] && wb_sel_i[1]) begin
      cmd_ff <= wb_dat_i[`NSTG_CMD_W-1:0];
    end
  end

  // pending until the sequencer takes the command
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pend_ff <= 1'b0;
    end else if (wb_req && wb_we_i && wb_adr_i == `NSTG_OFS_CMD &&
                 !busy && wb_sel_i[0] && wb_sel_i[1]) begin
      pend_ff <= 1'b1;
    end else if (state_ff == S_IDLE && nxt_state != S_IDLE) begin
      pend_ff <= 1'b0;
    end
  end

  // read data; unmapped offsets read as zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdat_ff <= '0;
    end else if (wb_req) begin
      rdat_ff <= '0;
      unique case (wb_adr_i)
        `NSTG_OFS_TIMING: rdat_ff <= timing_ff;
        `NSTG_OFS_CMD: rdat_ff[`NSTG_CMD_W-1:0] <= cmd_ff;
        `NSTG_OFS_STATUS: begin
          rdat_ff[`NSTG_F_RDATA] <= rdata_ff;
          rdat_ff[`NSTG_B_BUSY] <= busy;
          rdat_ff[`NSTG_B_RB] <= rb_i;
        end
        default: rdat_ff <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ****************************************************
  // access sequencer
  // ****************************************************

  // counts are frozen at the start of an access, so a timing write
  // in mid-access only applies from the next access onward
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tim_act_ff <= `NSTG_TIMING_RST;
    end else if (state_ff == S_IDLE && nxt_state != S_IDLE) begin
      tim_act_ff <= timing_ff;
    end
  end

  // next phase and its length; r/b is looked at only in idle, so the
  // guard phases hide a busy pulse from the flash only if it ends before they do
  always_comb begin
    nxt_state = state_ff;
    ld = 1'b0;
    ldv = '0;
    unique case (state_ff)
      S_IDLE: begin
        if (pend_ff && rb_i) begin
          ld = 1'b1;
          if (cmd_ff[`NSTG_B_WR]) begin
            nxt_state = S_WSU;
            ldv = one(timing_ff[`NSTG_F_WSU]);
          end else begin
            nxt_state = S_RSU;
            ldv = one(timing_ff[`NSTG_F_RSU]);
          end
        end
      end
      S_RSU: begin
        if (last) begin
          nxt_state = S_RSTB;
          ld = 1'b1;
          ldv = one(tim_act_ff[`NSTG_F_RW]);
        end
      end
      S_RSTB: begin
        if (last) begin
          nxt_state = S_RHLD;
          ld = 1'b1;
          ldv = one(tim_act_ff[`NSTG_F_RH]);
        end
      end
      S_RHLD: begin
        if (last) begin
          nxt_state = S_RGRD;
          ld = 1'b1;
          ldv = two(tim_act_ff[`NSTG_F_RB]);
        end
      end
      S_RGRD: begin
        if (last) begin
          nxt_state = S_IDLE;
        end
      end
      S_WSU: begin
        if (last) begin
          nxt_state = S_WSTB;
          ld = 1'b1;
          ldv = one(tim_act_ff[`NSTG_F_WW]);
        end
      end
      S_WSTB: begin
        if (last) begin
          nxt_state = S_WHLD;
          ld = 1'b1;
          ldv = one(tim_act_ff[`NSTG_F_WH]);
        end
      end
      S_WHLD: begin
        if (last) begin
          nxt_state = S_WGRD;
          ld = 1'b1;
          ldv = two(tim_act_ff[`NSTG_F_WB]);
        end
      end
      S_WGRD: begin
        if (last) begin
          nxt_state = S_IDLE;
        end
      end
    endcase
  end

  // phase length counter
  nstg_cnt u_cnt (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .load_i(ld),
    .val_i(ldv),
    .last_o(last)
  );

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // byte sampled on the last clock of the re low window
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_ff <= '0;
    end else if (state_ff == S_RSTB && last) begin
      rdata_ff <= dq_i;
    end
  end

  // ****************************************************
  // pin drive
  // ****************************************************

  // pins follow the phase being entered, so they line up with state_ff
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pins_ff <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, re_n: 1'b1,
                   we_n: 1'b1, dq_oe: 1'b0, dq: 8'h00};
    end else begin
      pins_ff <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, re_n: 1'b1,
                   we_n: 1'b1, dq_oe: 1'b0, dq: 8'h00};
      if (nxt_state inside {S_RSU, S_RSTB, S_RHLD}) begin
        pins_ff.ce_n <= 1'b0;
        pins_ff.cle <= cmd_ff[`NSTG_B_CLE];
        pins_ff.ale <= cmd_ff[`NSTG_B_ALE];
        pins_ff.re_n <= (nxt_state != S_RSTB);
      end
      if (nxt_state inside {S_WSU, S_WSTB, S_WHLD}) begin
        pins_ff.ce_n <= 1'b0;
        pins_ff.cle <= cmd_ff[`NSTG_B_CLE];
        pins_ff.ale <= cmd_ff[`NSTG_B_ALE];
        pins_ff.we_n <= (nxt_state != S_WSTB);
        pins_ff.dq_oe <= 1'b1;
        pins_ff.dq <= cmd_ff[`NSTG_F_DATA];
      end
    end
  end

  assign pins_o = pins_ff;

  // ****************************************************
  // checks
  // ****************************************************
  logic [7:0] st_cyc_ff;
  logic [7:0] since_we_ff;

  // cycles spent in the current phase, first cycle is one
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || state_ff != nxt_state) begin
      st_cyc_ff <= 8'h01;
    end else if (st_cyc_ff != 8'hff) begin
      st_cyc_ff <= st_cyc_ff + 8'h01;
    end
  end

  // cycles since the last we rise, saturating
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      since_we_ff <= 8'hff;
    end else if (state_ff == S_WSTB && nxt_state != S_WSTB) begin
      since_we_ff <= 8'h00;
    end else if (since_we_ff != 8'hff) begin
      since_we_ff <= since_we_ff + 8'h01;
    end
  end

  function automatic logic [7:0] eff(input logic [4:0] v);
    eff = (v == 5'h00) ? 8'h01 : {3'b000, v};
  endfunction

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_leave(nstg_state_t s);
    state_ff == s ##0 nxt_state != s;
  endsequence

  chk_rd_setup_len: assert property (
    s_leave(S_RSU) |-> st_cyc_ff == eff(one(tim_act_ff[`NSTG_F_RSU])))
    else $error("read setup length wrong");
  chk_re_low_len: assert property (
    s_leave(S_RSTB) |-> !pins_ff.re_n &&
    st_cyc_ff == eff(one(tim_act_ff[`NSTG_F_RW])) ##1 pins_ff.re_n)
    else $error("re low length wrong");
  chk_rd_hold_len: assert property (
    s_leave(S_RHLD) |-> !pins_ff.ce_n &&
    st_cyc_ff == eff(one(tim_act_ff[`NSTG_F_RH])))
    else $error("read hold length wrong");
  chk_rd_guard_len: assert property (
    s_leave(S_RGRD) |-> st_cyc_ff == eff(two(tim_act_ff[`NSTG_F_RB])))
    else $error("read ready guard length wrong");
  chk_wr_setup_len: assert property (
    s_leave(S_WSU) |-> pins_ff.dq_oe && pins_ff.we_n &&
    st_cyc_ff == eff(one(tim_act_ff[`NSTG_F_WSU])))
    else $error("write setup length wrong");
  chk_we_low_len: assert property (
    s_leave(S_WSTB) |-> st_cyc_ff == eff(one(tim_act_ff[`NSTG_F_WW]))
    ##1 pins_ff.we_n && $stable(pins_ff.dq))
    else $error("we low length wrong");
  chk_wr_hold_len: assert property (
    s_leave(S_WHLD) |-> pins_ff.dq_oe &&
    st_cyc_ff == eff(one(tim_act_ff[`NSTG_F_WH])))
    else $error("write hold length wrong");
  chk_wr_guard_len: assert property (
    s_leave(S_WGRD) |-> st_cyc_ff == eff(two(tim_act_ff[`NSTG_F_WB])))
    else $error("write ready guard length wrong");
  chk_we_to_re: assert property (
    $fell(pins_ff.re_n) && since_we_ff != 8'hff |->
    since_we_ff >= {3'b000, one(tim_act_ff[`NSTG_F_WH])} +
                   {3'b000, two(tim_act_ff[`NSTG_F_WB])})
    else $error("we rise to re fall too short");
  chk_ready_wait: assert property (
    $fell(pins_ff.ce_n) && !pins_ff.dq_oe |-> $past(rb_i) &&
    pins_ff.re_n && state_ff == S_RSU)
    else $error("read started without ready");
  chk_rd_release: assert property (
    state_ff inside {S_RSU, S_RSTB, S_RHLD} |-> !pins_ff.dq_oe)
    else $error("data driven during read");
  chk_timing_frozen: assert property (
    state_ff != S_IDLE && $past(state_ff) != S_IDLE |->
    $stable(tim_act_ff))
    else $error("counts changed in mid-access");

endmodule

// ### core/nstg_map.svh
// offsets, field positions, reset values and timing constants of the
// nand strobe timing generator; assumes an 8-bit wishbone byte address
`ifndef NSTG_MAP_SVH
`define NSTG_MAP_SVH

// register byte offsets
`define NSTG_OFS_TIMING 8'h00
`define NSTG_OFS_CMD 8'h04
`define NSTG_OFS_STATUS 8'h08

// timing register fields, each a count of bus clock periods, of period pairs for RB and WB
`define NSTG_F_RSU 3:0
`define NSTG_F_RH 7:4
`define NSTG_F_RW 11:8
`define NSTG_F_RB 15:12
`define NSTG_F_WSU 19:16
`define NSTG_F_WH 23:20
`define NSTG_F_WW 27:24
`define NSTG_F_WB 31:28
`define NSTG_TIMING_RST 32'hffff_ffff

// command register fields
`define NSTG_F_DATA 7:0
`define NSTG_B_WR 8
`define NSTG_B_CLE 9
`define NSTG_B_ALE 10
`define NSTG_CMD_W 11
`define NSTG_CMD_RST 11'h000

// status register fields
`define NSTG_F_RDATA 7:0
`define NSTG_B_BUSY 8
`define NSTG_B_RB 9

// bus clock rate, one count of a timing field is one period, two for the RB and WB guard fields
`define NSTG_CLK_PERIOD_NS 25
`define NSTG_CNT_W 5

`endif

// ### core/nstg_pkg.sv
// types shared by the nand strobe timing generator files
// assumes nstg_map.svh is on the include path
package nstg_pkg;

  // access phases
  typedef enum logic [3:0] {
    S_IDLE, S_RSU, S_RSTB, S_RHLD, S_RGRD,
    S_WSU, S_WSTB, S_WHLD, S_WGRD
  } nstg_state_t;

  // flash bus outputs, travelling together
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic re_n;
    logic we_n;
    logic dq_oe;
    logic [7:0] dq;
  } nstg_pins_t;

endpackage

// ### core/nstg_cnt.sv
// phase length down counter for the strobe timing generator
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
`include "nstg_map.svh"

module nstg_cnt (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // load with a phase length
  input wire logic load_i,
  input wire logic [`NSTG_CNT_W-1:0] val_i,
  // last cycle of the phase
  output logic last_o
);

  logic [`NSTG_CNT_W-1:0] cnt_ff;

  // a length of zero still takes one cycle, the state needs one edge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_ff <= '0;
    end else if (load_i) begin
      cnt_ff <= val_i;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - `NSTG_CNT_W'(1);
    end
  end

  assign last_o = (cnt_ff <= `NSTG_CNT_W'(1));

endmodule

// ### bench/nstg_flash_model.sv
// flash model: returns a stepping byte on read strobes, goes busy after
// strobes; assumes pins come from nstg_top on the same clock
`timescale 1ns/1ps
// ********************
// flash model
// ********************
module nstg_flash_model
  import nstg_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // bench controls
  input wire logic [7:0] rd_byte_i,
  input wire logic [7:0] busy_len_i,
  // flash pins
  input wire nstg_pins_t pins_i,
  output logic [7:0] dq_o,
  output logic rb_o,
  output logic [7:0] wr_byte_o
);
  logic [7:0] k_ff = 8'h00;
  logic [7:0] last_ff = 8'h5a;
  logic [7:0] bsy_ff = 8'h00;
  logic prev_ff = 1'b1;
  logic drv;
  // drive only while selected and read strobe low, else show the inverse
  assign drv = !pins_i.ce_n && !pins_i.re_n;
  assign dq_o = drv ? rd_byte_i + k_ff : ~last_ff;
  assign rb_o = (bsy_ff == 8'h00);
  // byte steps each strobe cycle, so only a sample at the end is right
  always @(posedge ref_clk_i) begin
    k_ff <= pins_i.re_n ? 8'h00 : k_ff + 8'h01;
    if (drv) last_ff <= dq_o;
    if (!pins_i.we_n) wr_byte_o <= pins_i.dq;
    prev_ff <= pins_i.re_n & pins_i.we_n;
    // busy at strobe end; short pulses must be ignored by the guard
    if (!prev_ff && pins_i.re_n && pins_i.we_n) bsy_ff <= busy_len_i;
    else if (bsy_ff != 8'h00) bsy_ff <= bsy_ff - 8'h01;
  end
endmodule

// ### bench/nstg_top_test.sv
// self-checking bench for nstg_top: timing sets, reads and writes
// assumes nstg_flash_model stands on the flash pins
`timescale 1ns/1ps
`include "nstg_map.svh"
// ********************
// bench top
// ********************
module nstg_top_test
  import nstg_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rdat, t;
  logic wb_ack_o, rb_i, exp_wr = 1'b0, prev_ce = 1'b1;
  logic [7:0] dq_i, wr_byte, dq0, busy_len = 8'h02;
  logic [1:0] lat;
  nstg_pins_t pins_o;
  logic [31:0] cfg [3] = '{32'h1213_1312, 32'h3121_2134, 32'h2f02_121f};
  int err_total = 0, check_count = 0, cyc = 0, mc = 0;
  int su, st, hd, gap, rr, ph, bad = 0, last_rise = 0, rbc = 0;

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  nstg_top uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_i(dq_i), .rb_i(rb_i),
    .pins_o(pins_o));
  nstg_flash_model flash (.ref_clk_i(ref_clk_i), .rd_byte_i(8'h3c),
    .busy_len_i(busy_len), .pins_i(pins_o), .dq_o(dq_i), .rb_o(rb_i),
    .wr_byte_o(wr_byte));

  task finish_test;
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task chk_ge(input int got, input int lo);
    check_count++;
    if (got < lo) begin
      err_total++;
      $display("wrong value at %0t: gap %0d below %0d", $time, got, lo);
    end
  endtask

  // a zero field stretches to one cycle
  function int ef(input logic [3:0] v);
    return (v == 4'h0) ? 1 : int'(v);
  endfunction

  // classic wishbone cycle, held until ack is seen at a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
          input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // no cycle count is assumed; only ack or the hang guard ends this wait
    do begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // poll status until the access and its guard are over
  task wait_idle;
    do wb(1'b0, `NSTG_OFS_STATUS, 4'hf, 32'h0);
    while (rdat[`NSTG_B_BUSY] !== 1'b0);
  endtask

  task cmd(input logic w, input int i);
    exp_wr = w;
    wb(1'b1, `NSTG_OFS_CMD, 4'h3, {21'h0, 2'(i), w, 8'ha0 + 8'(i)});
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      finish_test();
    end
  end

  // phase lengths per access; latches and data must hold while selected
  always @(posedge ref_clk_i) begin
    mc++;
    rbc = (rb_i === 1'b1) ? rbc + 1 : 0;
    if (pins_o.ce_n === 1'b0) begin
      if (prev_ce) begin
        su = 0;
        st = 0;
        hd = 0;
        ph = 0;
        lat = {pins_o.cle, pins_o.ale};
        dq0 = pins_o.dq;
      end
      if (!pins_o.re_n || !pins_o.we_n) begin
        if (st == 0) begin
          gap = mc - last_rise;
          rr = rbc;
        end
        st++;
        ph = 1;
      end else if (ph) begin
        if (hd == 0) last_rise = mc;
        hd++;
      end else su++;
      if ({pins_o.cle, pins_o.ale} !== lat || pins_o.dq_oe !== exp_wr ||
          (exp_wr && pins_o.dq !== dq0)) bad++;
    end
    prev_ce = pins_o.ce_n;
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    wb(1'b0, `NSTG_OFS_TIMING, 4'hf, 32'h0);
    chk(rdat, `NSTG_TIMING_RST);
    wb(1'b1, `NSTG_OFS_TIMING, 4'h1, 32'h0000_00a5);
    wb(1'b0, `NSTG_OFS_TIMING, 4'hf, 32'h0);
    chk(rdat, 32'hffff_ffa5);
    wb(1'b0, 8'h0c, 4'hf, 32'h0);
    chk(rdat, 32'h0);
    for (int i = 0; i < 3; i++) begin
      t = cfg[i];
      busy_len <= (i == 1) ? 8'h28 : 8'h02;
      wb(1'b1, `NSTG_OFS_TIMING, 4'hf, t);
      cmd(1'b1, i);
      wait_idle();
      chk(su, ef(t[19:16]));
      chk(st, ef(t[27:24]));
      chk(hd, ef(t[23:20]));
      chk({24'h0, wr_byte}, 8'ha0 + 8'(i));
      if (i > 0) begin
        chk_ge(gap, ef(cfg[i-1][7:4]) + 2 * ef(cfg[i-1][15:12]));
      end
      cmd(1'b0, i);
      wait_idle();
      chk(su, ef(t[3:0]));
      chk(st, ef(t[11:8]));
      chk(hd, ef(t[7:4]));
      chk_ge(gap, ef(t[23:20]) + 2 * ef(t[31:28]));
      chk_ge(rr, ef(t[3:0]));
      chk({24'h0, rdat[7:0]}, 8'h3c + 8'(ef(t[11:8]) - 1));
    end
    // a command and a timing write while busy must not touch this access
    cmd(1'b1, 0);
    wb(1'b1, `NSTG_OFS_CMD, 4'h3, 32'h0000_0255);
    wb(1'b1, `NSTG_OFS_TIMING, 4'hf, cfg[0]);
    wait_idle();
    chk(su, ef(cfg[2][19:16]));
    chk({24'h0, wr_byte}, 32'h0000_00a0);
    wb(1'b0, `NSTG_OFS_CMD, 4'hf, 32'h0);
    chk(rdat, 32'h0000_01a0);
    chk(bad, 0);
    finish_test();
  end
endmodule
